// ---- hw/tmr_pkg.sv ----
// package for the dual timer/counter block: register offsets, fields, resets, enums
// assumes one system clock domain and a plain address/strobe register port
package tmr_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h88;  // flags and run bits
  localparam logic [7:0] ADDR_MODE     = 8'h89;  // gate, counter select, mode
  localparam logic [7:0] ADDR_LOW_A    = 8'h8a;
  localparam logic [7:0] ADDR_LOW_B    = 8'h8b;
  localparam logic [7:0] ADDR_HIGH_A   = 8'h8c;
  localparam logic [7:0] ADDR_HIGH_B   = 8'h8d;
  localparam logic [7:0] ADDR_AUX_CLK  = 8'ha3;  // timer_aux_clock_ctrl
  localparam logic [7:0] ADDR_AUX_EXT  = 8'ha4;  // prescale extend and gate high bits

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_OVF_B    = 7;
  localparam int CTRL_RUN_B    = 6;
  localparam int CTRL_OVF_A    = 5;
  localparam int CTRL_RUN_A    = 4;
  localparam int MODE_GATE_B   = 7;
  localparam int MODE_CSEL_B   = 6;
  localparam int MODE_M_B      = 4;
  localparam int MODE_GATE_A   = 3;
  localparam int MODE_CSEL_A   = 2;
  localparam int MODE_M_A      = 0;
  localparam int AUX_STA       = 7;
  localparam int AUX_STO       = 6;
  localparam int AUX_SPEED_B   = 3;
  localparam int AUX_SPEED_A   = 2;
  localparam int AUX_CKOE_B    = 1;
  localparam int AUX_CKOE_A    = 0;
  localparam int EXT_GATE_HI_B = 5;
  localparam int EXT_GATE_HI_A = 4;
  localparam int EXT_PRESCALE  = 0;

  // ************************************************************
  // reset values and timing counts
  // ************************************************************
  localparam logic [7:0] RESET_REG   = 8'h00;
  localparam int         DIV_STD     = 12;   // machine cycle rate
  localparam int         DIV_SLOW    = 48;
  localparam int         DIV_SLOWEST = 192;
  localparam logic [7:0] DIV_LAST    = 8'(DIV_SLOWEST - 1);

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_PWM8,
    MODE_CNT16,
    MODE_RELOAD8,
    MODE_SPLIT
  } timer_mode_t;

  // sampled external inputs that feed gating and counting
  typedef struct packed {
    logic count_pin;
    logic gate_int;
    logic gate_alt;
    logic gate_aux;
  } ext_in_t;

endpackage : tmr_pkg

// ---- hw/edge_sampler.sv ----
// two-flop synchroniser plus timer-rate falling-edge sampler
// assumes raw asynchronous pin input and a one-cycle sample enable
`timescale 1ns/1ps

module edge_sampler
  import tmr_pkg::*;
(
  input  wire logic mclk,      // system clock
  input  wire logic reset_n,   // async reset, active low
  input  wire logic pin,       // raw pin level
  input  wire logic sample_en, // one sample per timer rate cycle
  output logic      level,     // synchronised level
  output logic      fall       // high on the enable after the one that saw 1 then 0
);

  logic meta;
  logic prev;
  logic seen;

  // synchroniser, first flop read only by the second
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta  <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
    end
  end

  // previous sample held between rate cycles
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      prev <= 1'b0;
    else if (sample_en)
      prev <= level;
  end

  // fall seen in one rate cycle, counted at the end of the next
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      seen <= 1'b0;
    else if (sample_en)
      seen <= prev & ~level;
  end

  assign fall = sample_en & seen;

endmodule : edge_sampler

// ---- hw/dual_timer_counter_clockout.sv ----
// two 8051-style timer/counters with clock-out outputs
// assumes register port on mclk; count and gate pins are asynchronous
`timescale 1ns/1ps

module dual_timer_counter_clockout
  import tmr_pkg::*;
(
  input  wire logic       mclk,          // 125 MHz system clock
  input  wire logic       reset_n,       // async reset, active low
  input  wire logic [7:0] addr,          // register address
  input  wire logic [7:0] wdata,         // write data
  input  wire logic       wr,            // write strobe
  input  wire logic       rd,            // read strobe
  output logic      [7:0] rdata,         // read data, cycle after rd
  input  wire logic       count_pin_a,   // external event pin a
  input  wire logic       count_pin_b,   // external event pin b
  input  wire logic       gate_int_a,    // ext int 0 active level
  input  wire logic       gate_alt_a,    // timer 2 overflow flag
  input  wire logic       gate_aux_a,    // keypad interrupt active
  input  wire logic       gate_int_b,    // ext int 1 active level
  input  wire logic       gate_alt_b,    // timer 3 overflow flag
  input  wire logic       gate_aux_b,    // uart1 tx flag active
  input  wire logic       low_osc_tick,  // internal low oscillator tick
  input  wire logic       wdt_tick,      // watchdog prescaler tick
  input  wire logic       irq_ack_a,     // vectoring clears ovf_flag_a
  input  wire logic       irq_ack_b,     // vectoring clears ovf_flag_b
  output logic            irq_a,         // timer a interrupt request
  output logic            irq_b,         // timer b interrupt request
  output logic            baud_tick,     // timer b overflow for serial
  output logic            clkout_pin_a,  // clock-out a level
  output logic            clkout_pin_b   // clock-out b level
);

  // ************************************************************
  // registers and state
  // ************************************************************
  logic [7:0] count_low_a, count_high_a, count_low_b, count_high_b;
  logic [7:0] mode_reg;
  logic       ovf_flag_a, ovf_flag_b, run_bit_a, run_bit_b;
  logic       speedup_a, speedup_b, clkout_enable_a, clkout_enable_b;
  logic       serial_start_seen, serial_stop_seen;
  logic       prescale_extend_a, gate_select_hi_a, gate_select_hi_b;
  logic [7:0] div_cnt;
  logic [1:0] osc_sync, wdt_sync, osc_d;
  logic       wdt_d;

  ext_in_t    ext_a, ext_b;
  logic       lvl_a, lvl_b, fall_a, fall_b;
  logic       tick12, tick48, tick192;
  logic       osc_tick, wdt_pulse;
  logic       rate_a, rate_b, inc_a, inc_b, inc_ah;
  logic       ovf_a, ovf_b, ovf_ah;
  logic       flag_set_a, flag_set_b;
  logic       open_a, open_b;
  timer_mode_t m_a, m_b;

  // gate source decode, both timers share the table
  function automatic logic gate_open(input logic [1:0] sel, input ext_in_t e);
    case (sel)
      2'h0:    gate_open = 1'b1;
      2'h1:    gate_open = e.gate_int;
      2'h2:    gate_open = e.gate_alt;
      default: gate_open = e.gate_aux;
    endcase
  endfunction : gate_open

  // effective mode, clock-out overrides to 8-bit reload
  function automatic timer_mode_t eff_mode(input logic [1:0] m, input logic cko);
    eff_mode = cko ? MODE_RELOAD8 : timer_mode_t'(m);
  endfunction : eff_mode

  // ************************************************************
  // synchronised inputs
  // ************************************************************
  edge_sampler u_samp_a (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .pin       (count_pin_a),
    .sample_en (tick12),
    .level     (lvl_a),
    .fall      (fall_a)
  );

  edge_sampler u_samp_b (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .pin       (count_pin_b),
    .sample_en (tick12),
    .level     (lvl_b),
    .fall      (fall_b)
  );

  // gate levels and tick inputs through two flops
  logic [5:0] gate_m, gate_s;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gate_m   <= 6'h00;
      gate_s   <= 6'h00;
      osc_sync <= 2'h0;
      wdt_sync <= 2'h0;
      osc_d    <= 2'h0;
      wdt_d    <= 1'b0;
    end
    else
    begin
      gate_m   <= {gate_int_a, gate_alt_a, gate_aux_a, gate_int_b, gate_alt_b, gate_aux_b};
      gate_s   <= gate_m;
      osc_sync <= {osc_sync[0], low_osc_tick};
      wdt_sync <= {wdt_sync[0], wdt_tick};
      osc_d    <= {osc_d[0], osc_sync[1]};
      wdt_d    <= wdt_sync[1];
    end
  end

  assign osc_tick  = osc_d[0] & ~osc_d[1];
  assign wdt_pulse = wdt_sync[1] & ~wdt_d;
  assign ext_a     = '{count_pin: lvl_a, gate_int: gate_s[5], gate_alt: gate_s[4],
                       gate_aux: gate_s[3]};
  assign ext_b     = '{count_pin: lvl_b, gate_int: gate_s[2], gate_alt: gate_s[1],
                       gate_aux: gate_s[0]};

  // ************************************************************
  // prescaler
  // ************************************************************
  // one free divider gives /12, /48 and /192 enables
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      div_cnt <= 8'h00;
    else if (div_cnt == DIV_LAST)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  assign tick12  = ((div_cnt % 8'(DIV_STD)) == 8'(DIV_STD - 1));
  assign tick48  = ((div_cnt % 8'(DIV_SLOW)) == 8'(DIV_SLOW - 1));
  assign tick192 = (div_cnt == DIV_LAST);

  // ************************************************************
  // clock selection and gating
  // ************************************************************
  assign m_a = eff_mode(mode_reg[MODE_M_A +: 2], clkout_enable_a);
  assign m_b = eff_mode(mode_reg[MODE_M_B +: 2], clkout_enable_b);

  // timer b clock table
  always_comb
  begin
    case ({speedup_b, mode_reg[MODE_CSEL_B]})
      2'h0:    rate_b = tick12;
      2'h1:    rate_b = fall_b;
      2'h2:    rate_b = 1'b1;
      default: rate_b = tick48;
    endcase
  end

  // timer a clock table
  always_comb
  begin
    case ({prescale_extend_a, speedup_a, mode_reg[MODE_CSEL_A]})
      3'h0:    rate_a = tick12;
      3'h1:    rate_a = fall_a;
      3'h2:    rate_a = 1'b1;
      3'h3:    rate_a = osc_tick;
      3'h4:    rate_a = tick48;
      3'h5:    rate_a = wdt_pulse;
      3'h6:    rate_a = tick192;
      default: rate_a = ovf_b;
    endcase
  end

  assign open_a = gate_open({gate_select_hi_a, mode_reg[MODE_GATE_A]}, ext_a);
  assign open_b = gate_open({gate_select_hi_b, mode_reg[MODE_GATE_B]}, ext_b);
  assign inc_a  = rate_a & run_bit_a & open_a;
  assign inc_b  = rate_b & run_bit_b & open_b & (m_b != MODE_SPLIT);
  // split high byte counts the internal machine rate, or every clock when speedup_a is set
  assign inc_ah = (m_a == MODE_SPLIT) & run_bit_b & (speedup_a ? 1'b1 : tick12);

  // ************************************************************
  // overflow detection
  // ************************************************************
  assign ovf_a  = inc_a & (m_a == MODE_CNT16 ? (&{count_high_a, count_low_a})
                                              : (&count_low_a));
  assign ovf_b  = inc_b & (m_b == MODE_CNT16 ? (&{count_high_b, count_low_b})
                                              : (&count_low_b));
  assign ovf_ah = inc_ah & (&count_high_a);
  assign flag_set_a = ovf_a;
  assign flag_set_b = (m_a == MODE_SPLIT) ? ovf_ah : ovf_b;
  assign baud_tick  = ovf_b;

  // ************************************************************
  // timer a counting
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_low_a  <= RESET_REG;
      count_high_a <= RESET_REG;
    end
    else if (wr && addr == ADDR_LOW_A)
      count_low_a <= wdata;
    else if (wr && addr == ADDR_HIGH_A)
      count_high_a <= wdata;
    else
    begin
      if (inc_a)
      begin
        case (m_a)
          MODE_CNT16:
          begin
            count_low_a <= count_low_a + 8'h01;
            if (&count_low_a)
              count_high_a <= count_high_a + 8'h01;
          end
          MODE_RELOAD8:
            count_low_a <= ovf_a ? count_high_a : count_low_a + 8'h01;
          default:
            count_low_a <= count_low_a + 8'h01;
        endcase
      end
      if (inc_ah)
        count_high_a <= count_high_a + 8'h01;
    end
  end

  // ************************************************************
  // timer b counting
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_low_b  <= RESET_REG;
      count_high_b <= RESET_REG;
    end
    else if (wr && addr == ADDR_LOW_B)
      count_low_b <= wdata;
    else if (wr && addr == ADDR_HIGH_B)
      count_high_b <= wdata;
    else if (inc_b)
    begin
      case (m_b)
        MODE_CNT16:
        begin
          count_low_b <= count_low_b + 8'h01;
          if (&count_low_b)
            count_high_b <= count_high_b + 8'h01;
        end
        MODE_RELOAD8:
          count_low_b <= ovf_b ? count_high_b : count_low_b + 8'h01;
        default:
          count_low_b <= count_low_b + 8'h01;
      endcase
    end
  end

  // ************************************************************
  // control register and flags
  // ************************************************************
  // hardware set wins over software or vector clear
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovf_flag_a <= 1'b0;
      ovf_flag_b <= 1'b0;
      run_bit_a  <= 1'b0;
      run_bit_b  <= 1'b0;
    end
    else
    begin
      if (wr && addr == ADDR_CTRL)
      begin
        run_bit_a <= wdata[CTRL_RUN_A];
        run_bit_b <= wdata[CTRL_RUN_B];
      end
      if (flag_set_a)
        ovf_flag_a <= 1'b1;
      else if (wr && addr == ADDR_CTRL)
        ovf_flag_a <= wdata[CTRL_OVF_A];
      else if (irq_ack_a)
        ovf_flag_a <= 1'b0;
      if (flag_set_b)
        ovf_flag_b <= 1'b1;
      else if (wr && addr == ADDR_CTRL)
        ovf_flag_b <= wdata[CTRL_OVF_B];
      else if (irq_ack_b)
        ovf_flag_b <= 1'b0;
    end
  end

  // clock-out rollovers raise no interrupt
  assign irq_a = ovf_flag_a & ~clkout_enable_a;
  assign irq_b = ovf_flag_b & ~(clkout_enable_b & (m_a != MODE_SPLIT));

  // mode and auxiliary registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_reg          <= RESET_REG;
      speedup_a         <= 1'b0;
      speedup_b         <= 1'b0;
      clkout_enable_a   <= 1'b0;
      clkout_enable_b   <= 1'b0;
      serial_start_seen <= 1'b0;
      serial_stop_seen  <= 1'b0;
      prescale_extend_a <= 1'b0;
      gate_select_hi_a  <= 1'b0;
      gate_select_hi_b  <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == ADDR_MODE)
        mode_reg <= wdata;
      if (addr == ADDR_AUX_CLK)
      begin
        serial_start_seen <= wdata[AUX_STA];
        serial_stop_seen  <= wdata[AUX_STO];
        speedup_b         <= wdata[AUX_SPEED_B];
        speedup_a         <= wdata[AUX_SPEED_A];
        clkout_enable_b   <= wdata[AUX_CKOE_B];
        clkout_enable_a   <= wdata[AUX_CKOE_A];
      end
      if (addr == ADDR_AUX_EXT)
      begin
        gate_select_hi_b  <= wdata[EXT_GATE_HI_B];
        gate_select_hi_a  <= wdata[EXT_GATE_HI_A];
        prescale_extend_a <= wdata[EXT_PRESCALE];
      end
    end
  end

  // ************************************************************
  // clock-out toggles
  // ************************************************************
  // toggle per overflow gives 2*(256-reload) input clocks per period
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clkout_pin_a <= 1'b0;
      clkout_pin_b <= 1'b0;
    end
    else
    begin
      if (clkout_enable_a && ovf_a)
        clkout_pin_a <= ~clkout_pin_a;
      if (clkout_enable_b && ovf_b)
        clkout_pin_b <= ~clkout_pin_b;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        ADDR_CTRL:    rdata <= {ovf_flag_b, run_bit_b, ovf_flag_a, run_bit_a, 4'h0};
        ADDR_MODE:    rdata <= mode_reg;
        ADDR_LOW_A:   rdata <= count_low_a;
        ADDR_LOW_B:   rdata <= count_low_b;
        ADDR_HIGH_A:  rdata <= count_high_a;
        ADDR_HIGH_B:  rdata <= count_high_b;
        ADDR_AUX_CLK: rdata <= {serial_start_seen, serial_stop_seen, 2'h0, speedup_b,
                                speedup_a, clkout_enable_b, clkout_enable_a};
        ADDR_AUX_EXT: rdata <= {2'h0, gate_select_hi_b, gate_select_hi_a, 3'h0,
                                prescale_extend_a};
        default:      rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

endmodule : dual_timer_counter_clockout

// ---- testbench/tmr_monitor.sv ----
// checker for the dual timer: port-level relations over time
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps

module tmr_monitor
  import tmr_pkg::*;
(
  input wire logic       mclk,         // clock
  input wire logic       reset_n,      // reset, active low
  input wire logic [7:0] addr,         // address
  input wire logic [7:0] wdata,        // write data
  input wire logic       wr,           // write strobe
  input wire logic       rd,           // read strobe
  input wire logic [7:0] rdata,        // read data
  input wire logic       irq_a,        // timer a request
  input wire logic       baud_tick,    // timer b overflow
  input wire logic       clkout_pin_a, // clock-out a
  input wire logic       clkout_pin_b  // clock-out b
);
  logic [7:0] mode;
  logic [7:0] aux;
  logic [7:0] ext;
  logic [7:0] hib;
  logic [1:0] run;
  logic       fast_b;

  // ************************************************************
  // shadows of the last software write to each field
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode <= 8'h00;
      aux  <= 8'h00;
      ext  <= 8'h00;
      hib  <= 8'h00;
      run  <= 2'b00;
    end
    else if (wr)
    begin
      case (addr)
        ADDR_MODE:    mode <= wdata;
        ADDR_AUX_CLK: aux  <= wdata & 8'hcf;
        ADDR_AUX_EXT: ext  <= wdata;
        ADDR_HIGH_B:  hib  <= wdata;
        ADDR_CTRL:    run  <= {wdata[CTRL_RUN_B], wdata[CTRL_RUN_A]};
        default:      ;
      endcase
    end
  end

  // timer b free running at full rate, reload of 0xfe
  assign fast_b = run[1] && aux[AUX_SPEED_B] && !mode[MODE_CSEL_B] && !mode[MODE_GATE_B]
                  && !ext[EXT_GATE_HI_B] && mode[5:4] == 2'd2 && mode[1:0] != 2'd3
                  && hib == 8'hfe;

  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_rdata_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");

  property p_aux_read;
    rd && addr == ADDR_AUX_CLK |=> rdata == $past(aux);
  endproperty
  a_aux_read: assert property (p_aux_read) else $error("aux readback wrong");

  property p_slow_gap;
    baud_tick && !(aux[AUX_SPEED_B] && !mode[MODE_CSEL_B]) |=> !baud_tick[*8] ##1 !baud_tick[*3];
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("overflow too fast");

  property p_fast_rate;
    baud_tick && fast_b ##1 fast_b && !wr |=> baud_tick;
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("full-rate reload period wrong");

  property p_hold_b;
    mode[5:4] == 2'd3 && mode[1:0] != 2'd3 && !aux[AUX_CKOE_B] |-> !baud_tick;
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("timer b overflowed in hold mode");

  property p_no_irq;
    aux[AUX_CKOE_A] |-> !irq_a;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt during clock-out");

  property p_clk_follow;
    aux[AUX_CKOE_B] && mode[1:0] != 2'd3
      |=> (clkout_pin_b != $past(clkout_pin_b)) == $past(baud_tick);
  endproperty
  a_clk_follow: assert property (p_clk_follow) else $error("clock-out b missed overflow");

  property p_clk_off;
    !aux[AUX_CKOE_B] |=> $stable(clkout_pin_b);
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock-out b moved while disabled");

  property p_clk_stop;
    !run[0] |=> $stable(clkout_pin_a);
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock-out a moved while stopped");

  c_fast: cover property (baud_tick && fast_b);
  c_clk:  cover property ($rose(clkout_pin_b));
  c_irq:  cover property (irq_a);
endmodule : tmr_monitor

// ---- testbench/event_pins.sv ----
// far-side model: external count pins and clock-out edge counter
// assumes one fire pulse per event, at least 60 cycles apart
`timescale 1ns/1ps

module event_pins
(
  input  wire logic       mclk,         // system clock
  input  wire logic       reset_n,      // reset, active low
  input  wire logic       fire,         // start one low pulse
  input  wire logic       clkout_pin_b, // clock-out b level
  output logic            count_pin_a,  // event pin a
  output logic            count_pin_b,  // event pin b
  output logic      [7:0] edges_b       // clock-out b toggles
);
  logic [5:0] low_left;
  logic       last_b;

  // low pulse of 30 cycles, pulled up otherwise
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      low_left <= 6'h00;
    else if (fire)
      low_left <= 6'h1e;
    else if (low_left != 6'h00)
      low_left <= low_left - 6'h01;
  end
  assign count_pin_a = (low_left == 6'h00);
  assign count_pin_b = (low_left == 6'h00);

  // count level changes seen on clock-out b
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_b  <= 1'b0;
      edges_b <= 8'h00;
    end
    else
    begin
      last_b  <= clkout_pin_b;
      edges_b <= edges_b + 8'(clkout_pin_b != last_b);
    end
  end
endmodule : event_pins

// ---- testbench/tb.sv ----
// directed testbench for the dual timer through its register port
// assumes tmr_pkg, the pin model and the checker are compiled first
`timescale 1ns/1ps

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t got %h exp %h", $time, g, e); end end

module tb;
  import tmr_pkg::*;
  logic       mclk, reset_n, wr, rd, fire, irq_ack_a, irq_ack_b, irq_a, irq_b;
  logic       gate_int_a, gate_alt_a, gate_aux_a, count_pin_a, count_pin_b;
  logic       baud_tick, clkout_pin_a, clkout_pin_b;
  logic [7:0] addr, wdata, rdata, edges_b, e0;
  int         failures, n_tests;
  logic [7:0] regs [4] = '{ADDR_LOW_A, ADDR_LOW_B, ADDR_HIGH_A, ADDR_HIGH_B};
  logic [7:0] all  [9] = '{ADDR_CTRL, ADDR_MODE, ADDR_LOW_A, ADDR_LOW_B, ADDR_HIGH_A,
                           ADDR_HIGH_B, ADDR_AUX_CLK, ADDR_AUX_EXT, 8'h90};

  dual_timer_counter_clockout dut
  (
    .mclk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .count_pin_a, .count_pin_b,
    .gate_int_a, .gate_alt_a, .gate_aux_a, .gate_int_b(1'b0), .gate_alt_b(1'b0),
    .gate_aux_b(1'b0), .low_osc_tick(1'b0), .wdt_tick(1'b0), .irq_ack_a, .irq_ack_b,
    .irq_a, .irq_b, .baud_tick, .clkout_pin_a, .clkout_pin_b
  );

  event_pins pins
  (
    .mclk, .reset_n, .fire, .clkout_pin_b, .count_pin_a, .count_pin_b, .edges_b
  );

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    @(negedge mclk);
    `CHK(rdata, e)
  endtask : rd_chk

  // run n edges, checking flags just before the stop
  task automatic run_for(input logic [7:0] c, input int n, input logic [7:0] f);
    wr_reg(ADDR_CTRL, c);
    repeat (n - 4) @(posedge mclk);
    rd_chk(ADDR_CTRL, f);
    wr_reg(ADDR_CTRL, 8'h00);
  endtask : run_for

  // set up clock, mode and counts, run, read one register
  task automatic rate(input logic [7:0] e, x, m, c, lo, hi, input int n,
                      input logic [7:0] f, ra, ex);
    wr_reg(ADDR_AUX_EXT, e);
    wr_reg(ADDR_AUX_CLK, x);
    wr_reg(ADDR_MODE, m);
    foreach (regs[i]) wr_reg(regs[i], i < 2 ? lo : hi);
    run_for(c, n, f);
    rd_chk(ra, ex);
  endtask : rate

  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // ************************************************************
  // clock, watchdog, sequence
  // ************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    #400000;
    failures++;
    summarize();
  end

  initial
  begin
    {reset_n, wr, rd, fire, irq_ack_a, irq_ack_b} = 6'h00;
    {gate_int_a, gate_alt_a, gate_aux_a} = 3'b000;
    {addr, wdata} = 16'h0000;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    wr_reg(8'h90, 8'hff);
    foreach (all[i]) rd_chk(all[i], 8'h00);
    wr_reg(ADDR_AUX_CLK, 8'hff);
    rd_chk(ADDR_AUX_CLK, 8'hcf);
    rate(8'h00, 8'h00, 8'h01, 8'h10, 8'h00, 8'h00, 240, 8'h10, ADDR_LOW_A, 8'h14);
    rate(8'h00, 8'h04, 8'h01, 8'h10, 8'h00, 8'h00, 20, 8'h10, ADDR_LOW_A, 8'h14);
    rate(8'h01, 8'h00, 8'h01, 8'h10, 8'h00, 8'h00, 240, 8'h10, ADDR_LOW_A, 8'h05);
    rate(8'h01, 8'h04, 8'h01, 8'h10, 8'h00, 8'h00, 384, 8'h10, ADDR_LOW_A, 8'h02);
    rate(8'h00, 8'h00, 8'h10, 8'h40, 8'h00, 8'h00, 240, 8'h40, ADDR_LOW_B, 8'h14);
    rate(8'h00, 8'h08, 8'h10, 8'h40, 8'h00, 8'h00, 20, 8'h40, ADDR_LOW_B, 8'h14);
    rate(8'h00, 8'h08, 8'h60, 8'h40, 8'hfe, 8'h00, 240, 8'hc0, ADDR_LOW_B, 8'h03);
    rate(8'h00, 8'h04, 8'h01, 8'h10, 8'hf0, 8'h00, 20, 8'h10, ADDR_HIGH_A, 8'h01);
    rd_chk(ADDR_LOW_A, 8'h04);
    rate(8'h00, 8'h04, 8'h00, 8'h10, 8'hff, 8'hff, 20, 8'h30, ADDR_AUX_CLK, 8'h04);
    rate(8'h00, 8'h04, 8'h02, 8'h10, 8'hfe, 8'hfd, 5, 8'h30, ADDR_LOW_A, 8'hfd);
    rd_chk(ADDR_HIGH_A, 8'hfd);
    rate(8'h00, 8'h08, 8'h30, 8'h40, 8'h10, 8'h00, 20, 8'h40, ADDR_LOW_B, 8'h10);
    rate(8'h00, 8'h04, 8'h07, 8'h50, 8'h00, 8'hf0, 24, 8'hd0, ADDR_HIGH_A, 8'h08);
    rd_chk(ADDR_LOW_A, 8'h00);
    for (int g = 1; g < 4; g++)
    begin
      @(posedge mclk);
      {gate_aux_a, gate_alt_a, gate_int_a} <= ~(3'b001 << (g - 1));
      rate({3'b000, g[1], 4'h0}, 8'h04, {4'h0, g[0], 3'b001}, 8'h10, 8'h00, 8'h00, 20,
           8'h10, ADDR_LOW_A, 8'h00);
      @(posedge mclk);
      {gate_aux_a, gate_alt_a, gate_int_a} <= 3'b111;
      rate({3'b000, g[1], 4'h0}, 8'h04, {4'h0, g[0], 3'b001}, 8'h10, 8'h00, 8'h00, 20,
           8'h10, ADDR_LOW_A, 8'h14);
    end
    wr_reg(ADDR_CTRL, 8'ha0);
    @(negedge mclk);
    `CHK({irq_a, irq_b}, 2'b11)
    @(posedge mclk);
    {irq_ack_a, irq_ack_b} <= 2'b11;
    @(posedge mclk);
    {irq_ack_a, irq_ack_b} <= 2'b00;
    @(negedge mclk);
    `CHK({irq_a, irq_b}, 2'b00)
    wr_reg(ADDR_AUX_CLK, 8'h01);
    wr_reg(ADDR_CTRL, 8'h20);
    @(negedge mclk);
    `CHK(irq_a, 1'b0)
    fork
      rate(8'h00, 8'h00, 8'h55, 8'h50, 8'h00, 8'h00, 400, 8'h50, ADDR_LOW_A, 8'h03);
      repeat (3)
      begin
        repeat (80) @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
      end
    join
    rd_chk(ADDR_LOW_B, 8'h03);
    wr_reg(ADDR_AUX_EXT, 8'h01);
    wr_reg(ADDR_AUX_CLK, 8'h0c);
    wr_reg(ADDR_MODE, 8'h25);
    foreach (regs[i]) wr_reg(regs[i], i[0] ? 8'hfe : 8'h00);
    wr_reg(ADDR_AUX_CLK, 8'h0e);
    e0 = edges_b;
    run_for(8'h50, 40, 8'hd0);
    repeat (2) @(negedge mclk);
    `CHK(8'(edges_b - e0), 8'h14)
    rd_chk(ADDR_LOW_A, 8'h14);
    summarize();
  end
endmodule : tb

bind dual_timer_counter_clockout tmr_monitor mon
(
  .mclk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .irq_a, .baud_tick, .clkout_pin_a,
  .clkout_pin_b
);
